// *** inc/meter_pwm_pkg.sv ***
// Constants shared by the stepper-meter PWM driver
package meter_pwm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int METERS = 6;
    localparam int METERS_A = 4;
    localparam int PINS = 24;
    localparam int OUTS_A = 8;
    localparam int OUTS_B = 4;
    // Register byte offsets
    localparam logic [7:0] TIMER_MODE_CTRL_A_OFS = 8'h00;
    localparam logic [7:0] TIMER_MODE_CTRL_B_OFS = 8'h04;
    localparam logic [7:0] COUNTER_VALUE_OFS = 8'h08;
    localparam logic [7:0] PORT_CTRL_OFS = 8'h0c;
    localparam logic [7:0] PORT_DATA_OFS = 8'h10;
    localparam int METER_BASE_OFS = 32;
    localparam int METER_STRIDE = 8;
    localparam int METER_CTRL_OFS = 0;
    localparam int METER_CMP_OFS = 4;
    // Timer mode control fields
    localparam int COUNT_ENABLE_BIT = 0;
    localparam int COUNT_CLOCK_SELECT_LSB = 1;
    localparam int COUNT_CLOCK_SELECT_W = 3;
    // Counter value fields
    localparam int COUNTER_A_LSB = 0;
    localparam int COUNTER_B_LSB = 8;
    // Port control fields
    localparam int PORT_OUTPUT_SELECT_BIT = 0;
    // Meter channel control fields
    localparam int QUADRANT_LOW_BIT = 0;
    localparam int QUADRANT_HIGH_BIT = 1;
    localparam int SINE_ADD_ENABLE_BIT = 2;
    localparam int COSINE_ADD_ENABLE_BIT = 3;
    localparam int TRANSFER_ENABLE_BIT = 4;
    // Compare fields
    localparam int SINE_COMPARE_LSB = 0;
    localparam int COSINE_COMPARE_LSB = 8;
    // Counter terminal value and values after reset
    localparam logic [7:0] COUNTER_TOP = 8'hff;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [3:0] TIMER_MODE_RESET = 4'h0;
    localparam logic [4:0] METER_CTRL_RESET = 5'h00;
endpackage

// *** logic/stepper_meter_pwm_driver.sv ***
// Stepper-meter PWM driver: two timebases, six meters, full-bridge routing
// Functional notes
// - Each counter advances on the count clock picked by its own clock-select field.
// - Both counters clear to zero on system reset.
// - A counter counts only while its count-enable bit is set and holds otherwise.
// - On overflow with the transfer flag set, master compare data is copied to the slave latch.
// - The transfer flag clears in the same cycle as that copy.
// - With addition on, the falling edge alternates between N and N+1 each period.
// - Sine and cosine each take the addition only when their own add bit is 1.
// - With addition off, the falling edge is always at count N+1.
// - Meter 1 to 4 outputs are staggered one count clock of timebase A apart.
// - Meter 5 and 6 outputs are staggered one count clock of timebase B apart.
// - The quadrant field routes PWM to the plus or minus pins; the idle pin of a pair is 0.
// - With port-output select set, all meter pins are plain port pins.
// - Compare data writes are blocked while the transfer flag is 1.
`timescale 1ns/10ps
module stepper_meter_pwm_driver (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [meter_pwm_pkg::ADDR_W-1:0] addr_i,
    input wire logic [meter_pwm_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [meter_pwm_pkg::DATA_W-1:0] rdata_o,
    output logic [meter_pwm_pkg::PINS-1:0] meter_pins_o
);
    import meter_pwm_pkg::*;

    // Package sizes must match the pin, tap and register layout
    if (PINS != 4 * METERS) begin : g_pins_chk
        $error("four pins per meter expected");
    end
    if (OUTS_A != 2 * METERS_A) begin : g_taps_a_chk
        $error("timebase A tap count does not match its meters");
    end
    if (OUTS_B != 2 * (METERS - METERS_A)) begin : g_taps_b_chk
        $error("timebase B tap count does not match its meters");
    end
    if (METERS_A < 1 || METERS_A >= METERS) begin : g_split_chk
        $error("both timebases need at least one meter");
    end
    if (COUNT_CLOCK_SELECT_W != 3) begin : g_sel_chk
        $error("clock select must be three bits wide");
    end
    if (ADDR_W != 8 || DATA_W < PINS || DATA_W != 32) begin : g_bus_chk
        $error("register bus must be 8 address and 32 data bits");
    end

    typedef struct packed {
        logic [7:0] presc;
        logic [1:0][3:0] timer_mode;
        logic [1:0][7:0] counter;
        logic [1:0] odd_period;
        logic [METERS-1:0][1:0] quadrant;
        logic [METERS-1:0] transfer_enable_flag;
        logic [METERS-1:0][1:0] add_master;
        logic [METERS-1:0][1:0] add_slave;
        logic [METERS-1:0][1:0][7:0] cmp_master;
        logic [METERS-1:0][1:0][7:0] cmp_slave;
        logic port_output_select;
        logic [PINS-1:0] port_data;
        logic [OUTS_A-1:0][OUTS_A-1:0] hist_a;
        logic [OUTS_B-1:0][OUTS_B-1:0] hist_b;
        logic [PINS-1:0] pins;
        logic [DATA_W-1:0] rdata;
    } state_s;

    state_s s_reg;
    state_s s_next;
    logic [1:0] tick;
    logic [1:0] run;
    logic [1:0] ovf;
    logic [OUTS_A-1:0] raw_a;
    logic [OUTS_B-1:0] raw_b;
    logic [METERS*2-1:0] delayed;

    function automatic logic count_tick(input logic [7:0] presc, input logic [2:0] sel);
        logic [8:0] wide;
        logic [7:0] mask;
        wide = (9'h001 << sel) - 9'h001;
        mask = wide[7:0];
        return (presc & mask) == mask;
    endfunction

    // High from counter zero up to the compare point
    function automatic logic pwm_level(input logic [7:0] cnt, input logic [7:0] cmp,
                                       input logic add, input logic odd);
        if (add && odd) begin
            return cnt < cmp;
        end
        return cnt <= cmp;
    endfunction

    function automatic logic [7:0] meter_addr(input int m, input int ofs);
        return 8'(METER_BASE_OFS + m * METER_STRIDE + ofs);
    endfunction

    always_comb begin
        int tb;
        int j;
        logic sin_neg;
        logic cos_neg;
        logic [3:0] quad_pins;
        s_next = s_reg;
        tb = 0;
        j = 0;
        sin_neg = 1'b0;
        cos_neg = 1'b0;
        quad_pins = 4'h0;
        raw_a = '0;
        raw_b = '0;
        delayed = '0;
        s_next.presc = s_reg.presc + 8'h01;
        for (int i = 0; i < 2; i++) begin
            tick[i] = count_tick(s_reg.presc,
                s_reg.timer_mode[i][COUNT_CLOCK_SELECT_LSB +: COUNT_CLOCK_SELECT_W]);
            run[i] = tick[i] && s_reg.timer_mode[i][COUNT_ENABLE_BIT];
            ovf[i] = run[i] && (s_reg.counter[i] == COUNTER_TOP);
            if (run[i]) begin
                s_next.counter[i] = s_reg.counter[i] + 8'h01;
            end
            if (ovf[i]) begin
                s_next.odd_period[i] = ~s_reg.odd_period[i];
            end
        end
        for (int m = 0; m < METERS; m++) begin
            tb = (m < METERS_A) ? 0 : 1;
            if (ovf[tb] && s_reg.transfer_enable_flag[m]) begin
                s_next.cmp_slave[m] = s_reg.cmp_master[m];
                s_next.add_slave[m] = s_reg.add_master[m];
                s_next.transfer_enable_flag[m] = 1'b0;
            end
            for (int c = 0; c < 2; c++) begin
                j = (m < METERS_A) ? 2 * m + c : 2 * (m - METERS_A) + c;
                // Each channel uses its own add bit
                if (m < METERS_A) begin
                    raw_a[j] = pwm_level(s_reg.counter[tb], s_reg.cmp_slave[m][c],
                                         s_reg.add_slave[m][c], s_reg.odd_period[tb]);
                    delayed[2 * m + c] = s_reg.hist_a[j][j];
                end else begin
                    raw_b[j] = pwm_level(s_reg.counter[tb], s_reg.cmp_slave[m][c],
                                         s_reg.add_slave[m][c], s_reg.odd_period[tb]);
                    delayed[2 * m + c] = s_reg.hist_b[j][j];
                end
            end
        end
        // Stagger taps; output k waits k+1 count clocks
        if (tick[0]) begin
            s_next.hist_a[0] = raw_a;
            for (int k = 1; k < OUTS_A; k++) begin
                s_next.hist_a[k] = s_reg.hist_a[k-1];
            end
        end
        if (tick[1]) begin
            s_next.hist_b[0] = raw_b;
            for (int k = 1; k < OUTS_B; k++) begin
                s_next.hist_b[k] = s_reg.hist_b[k-1];
            end
        end
        // Pin order per meter: sine plus, sine minus, cosine plus, cosine minus
        for (int m = 0; m < METERS; m++) begin
            sin_neg = s_reg.quadrant[m][QUADRANT_HIGH_BIT];
            cos_neg = s_reg.quadrant[m][QUADRANT_HIGH_BIT] ^ s_reg.quadrant[m][QUADRANT_LOW_BIT];
            quad_pins[0] = delayed[2 * m] && !sin_neg;
            quad_pins[1] = delayed[2 * m] && sin_neg;
            quad_pins[2] = delayed[2 * m + 1] && !cos_neg;
            quad_pins[3] = delayed[2 * m + 1] && cos_neg;
            s_next.pins[4 * m +: 4] = quad_pins;
        end
        if (s_reg.port_output_select) begin
            s_next.pins = s_reg.port_data;
        end
        if (wr_en_i) begin
            case (addr_i)
                TIMER_MODE_CTRL_A_OFS: s_next.timer_mode[0] = wdata_i[3:0];
                TIMER_MODE_CTRL_B_OFS: s_next.timer_mode[1] = wdata_i[3:0];
                PORT_CTRL_OFS: s_next.port_output_select = wdata_i[PORT_OUTPUT_SELECT_BIT];
                PORT_DATA_OFS: s_next.port_data = wdata_i[PINS-1:0];
                default: begin
                end
            endcase
            for (int m = 0; m < METERS; m++) begin
                // Locked while a transfer is pending
                if (!s_reg.transfer_enable_flag[m]) begin
                    if (addr_i == meter_addr(m, METER_CTRL_OFS)) begin
                        s_next.quadrant[m] = wdata_i[QUADRANT_HIGH_BIT:QUADRANT_LOW_BIT];
                        s_next.add_master[m][0] = wdata_i[SINE_ADD_ENABLE_BIT];
                        s_next.add_master[m][1] = wdata_i[COSINE_ADD_ENABLE_BIT];
                        s_next.transfer_enable_flag[m] = wdata_i[TRANSFER_ENABLE_BIT];
                    end
                    if (addr_i == meter_addr(m, METER_CMP_OFS)) begin
                        s_next.cmp_master[m][0] = wdata_i[SINE_COMPARE_LSB +: 8];
                        s_next.cmp_master[m][1] = wdata_i[COSINE_COMPARE_LSB +: 8];
                    end
                end
            end
        end
        s_next.rdata = '0;
        if (rd_en_i) begin
            case (addr_i)
                TIMER_MODE_CTRL_A_OFS: s_next.rdata = {28'h0000000, s_reg.timer_mode[0]};
                TIMER_MODE_CTRL_B_OFS: s_next.rdata = {28'h0000000, s_reg.timer_mode[1]};
                COUNTER_VALUE_OFS: s_next.rdata = {16'h0000, s_reg.counter[1], s_reg.counter[0]};
                PORT_CTRL_OFS: s_next.rdata = {31'h00000000, s_reg.port_output_select};
                PORT_DATA_OFS: s_next.rdata = {8'h00, s_reg.port_data};
                default: begin
                end
            endcase
            for (int m = 0; m < METERS; m++) begin
                if (addr_i == meter_addr(m, METER_CTRL_OFS)) begin
                    s_next.rdata = {27'h0000000, s_reg.transfer_enable_flag[m],
                                    s_reg.add_master[m][1], s_reg.add_master[m][0],
                                    s_reg.quadrant[m]};
                end
                if (addr_i == meter_addr(m, METER_CMP_OFS)) begin
                    s_next.rdata = {16'h0000, s_reg.cmp_master[m][1], s_reg.cmp_master[m][0]};
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.counter <= {COUNTER_RESET, COUNTER_RESET};
            s_reg.timer_mode <= {TIMER_MODE_RESET, TIMER_MODE_RESET};
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_o = s_reg.rdata;
    assign meter_pins_o = s_reg.pins;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_reset_clear: assert property (disable iff (1'b0)
        rst_i |=> (s_reg.counter[0] == 8'h00) && (s_reg.counter[1] == 8'h00))
        else $error("counters not cleared by reset");
    a_count_step: assert property (run[0]
        |=> s_reg.counter[0] == $past(s_reg.counter[0]) + 8'h01)
        else $error("counter A did not step on its count clock");
    a_count_hold: assert property (!run[1] |=> $stable(s_reg.counter[1]))
        else $error("counter B moved without enable and tick");
    a_slave_load: assert property (ovf[0] && s_reg.transfer_enable_flag[0]
        |=> s_reg.cmp_slave[0] == $past(s_reg.cmp_master[0]))
        else $error("slave latch not loaded at overflow");
    a_flag_clear: assert property (ovf[1] && s_reg.transfer_enable_flag[5]
        |=> !s_reg.transfer_enable_flag[5])
        else $error("transfer flag not cleared with transfer");
    a_slave_hold: assert property (!(ovf[0] && s_reg.transfer_enable_flag[1])
        |=> $stable(s_reg.cmp_slave[1]))
        else $error("slave latch changed mid period");
    a_write_block: assert property (wr_en_i && s_reg.transfer_enable_flag[2]
        && addr_i == meter_addr(2, METER_CMP_OFS) |=> $stable(s_reg.cmp_master[2]))
        else $error("compare write accepted while transfer pending");
    a_fall_plain: assert property (!s_reg.add_slave[0][0] && s_reg.cmp_slave[0][0] != 8'hff
        && s_reg.counter[0] == s_reg.cmp_slave[0][0] + 8'h01 |-> !raw_a[0])
        else $error("plain output high past N");
    a_fall_add: assert property (s_reg.add_slave[0][1] && s_reg.odd_period[0]
        && s_reg.counter[0] == s_reg.cmp_slave[0][1] |-> !raw_a[1])
        else $error("added output not falling at N");
    a_add_split: assert property (!s_reg.add_slave[0][0] && s_reg.add_slave[0][1]
        && s_reg.odd_period[0] && s_reg.counter[0] == s_reg.cmp_slave[0][0]
        |-> raw_a[0])
        else $error("sine took cosine add bit");
    a_stagger_a: assert property (tick[0]
        |=> s_reg.hist_a[3] == $past(s_reg.hist_a[2]))
        else $error("timebase A stagger broken");
    a_stagger_b: assert property (tick[1]
        |=> s_reg.hist_b[1] == $past(s_reg.hist_b[0]))
        else $error("timebase B stagger broken");
    a_port_mode: assert property (s_reg.port_output_select
        |=> meter_pins_o == $past(s_reg.port_data))
        else $error("port mode pins wrong");
    a_idle_pin: assert property (!s_reg.port_output_select && s_reg.quadrant[0] == 2'b00
        |=> !meter_pins_o[1] && !meter_pins_o[3])
        else $error("idle bridge pin driven");
    a_count_hold_a: assert property (!run[0] |=> $stable(s_reg.counter[0]))
        else $error("counter A moved without enable and tick");
    a_transfer_b: assert property (ovf[1] && s_reg.transfer_enable_flag[4]
        |=> s_reg.cmp_slave[4] == $past(s_reg.cmp_master[4]))
        else $error("timebase B slave latch not loaded");
    a_flag_clear_a: assert property (ovf[0] && s_reg.transfer_enable_flag[3]
        |=> !s_reg.transfer_enable_flag[3])
        else $error("timebase A transfer flag not cleared");
    a_odd_toggle: assert property (ovf[1]
        |=> s_reg.odd_period[1] != $past(s_reg.odd_period[1]))
        else $error("period parity not toggled at overflow");
    a_idle_pair: assert property (!s_reg.port_output_select
        && s_reg.quadrant[0] == 2'b10 |=> !meter_pins_o[0] && !meter_pins_o[2])
        else $error("idle bridge pin driven in quadrant three");

    c_transfer: cover property (ovf[0] && s_reg.transfer_enable_flag[0]);
    c_add_odd: cover property (s_reg.add_slave[0][0] && s_reg.odd_period[0] && run[0]);
    c_port_mode: cover property (s_reg.port_output_select && wr_en_i);
    c_quad_four: cover property (s_reg.quadrant[4] == 2'b11 && ovf[1]);
    c_add_cos: cover property (s_reg.add_slave[0][1] && s_reg.odd_period[0] && run[0]);
endmodule

// *** sim/coil_load_model.sv ***
// Coil load model: records driven pins and bridge shoot-through
`timescale 1ns/10ps
module coil_load_model (
    input wire logic ref_clk_i,
    input wire logic clear_i,
    input wire logic [meter_pwm_pkg::PINS-1:0] pins_i,
    output logic [meter_pwm_pkg::PINS-1:0] seen_o,
    output logic short_o
);
    import meter_pwm_pkg::*;
    always_ff @(posedge ref_clk_i) begin
        if (clear_i) begin
            seen_o <= '0;
            short_o <= 1'b0;
        end else begin
            seen_o <= seen_o | pins_i;
            // Both ends of one coil high would short the bridge
            for (int m = 0; m < METERS; m++) begin
                if (pins_i[4*m+:2] == 2'b11 || pins_i[4*m+2+:2] == 2'b11) begin
                    short_o <= 1'b1;
                end
            end
        end
    end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the stepper-meter PWM driver
`timescale 1ns/10ps
module tb_top;
    import meter_pwm_pkg::*;
    logic ref_clk_i;
    logic rst_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic wr_en_i;
    logic rd_en_i;
    logic [DATA_W-1:0] rdata_o;
    logic [PINS-1:0] meter_pins_o;
    logic clear_i;
    logic [PINS-1:0] seen_o;
    logic short_o;
    int error_cnt = 0;
    int checks = 0;
    logic [7:0] ns [METERS];
    logic [7:0] nc [METERS];
    logic [31:0] d1;
    logic [31:0] d2;
    int w1;
    int w2;

    stepper_meter_pwm_driver stepper_meter_pwm_driver_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .rdata_o(rdata_o), .meter_pins_o(meter_pins_o));
    coil_load_model coil_load_model_i (.ref_clk_i(ref_clk_i), .clear_i(clear_i),
        .pins_i(meter_pins_o), .seen_o(seen_o), .short_o(short_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    task automatic wrap_up();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic fail_wait();
        error_cnt++;
        wrap_up();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_en_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_en_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_en_i <= 1'b0;
        @(negedge ref_clk_i);
        d = rdata_o;
    endtask
    function automatic logic [7:0] ctrl_adr(input int m);
        return 8'(METER_BASE_OFS + METER_STRIDE * m + METER_CTRL_OFS);
    endfunction
    function automatic logic [7:0] cmp_adr(input int m);
        return 8'(METER_BASE_OFS + METER_STRIDE * m + METER_CMP_OFS);
    endfunction
    // Pins sin+, sin-, cos+, cos- that carry PWM per quadrant
    function automatic logic [3:0] qmask(input int q);
        case (q)
            0: return 4'b0101;
            1: return 4'b1001;
            2: return 4'b1010;
            default: return 4'b0110;
        endcase
    endfunction
    task automatic wait_lvl(input int p, input logic v);
        int t;
        for (t = 0; t < 1200 && meter_pins_o[p] !== v; t++) @(negedge ref_clk_i);
        if (meter_pins_o[p] !== v) fail_wait();
    endtask
    task automatic pulse_w(input int p, output int w);
        @(negedge ref_clk_i);
        wait_lvl(p, 1'b0);
        wait_lvl(p, 1'b1);
        for (w = 0; w < 600 && meter_pins_o[p] === 1'b1; w++) @(negedge ref_clk_i);
    endtask
    task automatic stagger(input int b, input int step);
        int first [4];
        first = '{0, 0, 0, 0};
        @(negedge ref_clk_i);
        wait_lvl(b, 1'b0);
        wait_lvl(b, 1'b1);
        for (int t = 0; t < 40; t++) begin
            for (int j = 1; j < 4; j++) begin
                if (first[j] == 0 && meter_pins_o[b+2*j] === 1'b1) first[j] = t;
            end
            @(negedge ref_clk_i);
        end
        for (int j = 1; j < 4; j++) chk(32'(first[j]), 32'(j * step));
    endtask
    task automatic wait_flag(input int m);
        logic [31:0] d;
        d = 32'h10;
        for (int t = 0; t < 400 && d[TRANSFER_ENABLE_BIT] !== 1'b0; t++) rd(ctrl_adr(m), d);
        if (d[TRANSFER_ENABLE_BIT] !== 1'b0) fail_wait();
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
    endtask

    initial begin
        rst_i = 1'b1;
        addr_i = '0;
        wdata_i = '0;
        wr_en_i = 1'b0;
        rd_en_i = 1'b0;
        clear_i = 1'b1;
        void'($urandom(85));
        do_reset();
        clear_i <= 1'b0;
        rd(TIMER_MODE_CTRL_A_OFS, d1);
        chk(d1, 32'h0);
        @(negedge ref_clk_i);
        chk(rdata_o, 32'h0);
        wr(8'h80, $urandom);
        rd(8'h80, d1);
        chk(d1, 32'h0);
        for (int s = 0; s < 8; s++) begin
            wr(TIMER_MODE_CTRL_A_OFS, 32'((s << COUNT_CLOCK_SELECT_LSB) | 1));
            rd(COUNTER_VALUE_OFS, d1);
            repeat (8 * (1 << s) - 2) @(posedge ref_clk_i);
            rd(COUNTER_VALUE_OFS, d2);
            chk(32'(8'(d2[7:0] - d1[7:0])), 32'h8);
            chk(32'(d2[15:8]), 32'h0);
        end
        wr(TIMER_MODE_CTRL_A_OFS, 32'h0);
        rd(COUNTER_VALUE_OFS, d1);
        rd(COUNTER_VALUE_OFS, d2);
        chk(d2, d1);
        for (int m = 0; m < METERS; m++) begin
            ns[m] = 8'(20 + $urandom % 180);
            nc[m] = 8'(20 + $urandom % 180);
            wait_flag(m);
            wr(cmp_adr(m), {16'h0, nc[m], ns[m]});
            wr(ctrl_adr(m), 32'h10);
        end
        wr(cmp_adr(0), 32'h0000_0303);
        wr(ctrl_adr(0), 32'h0000_0003);
        wr(cmp_adr(2), 32'h0000_0505);
        rd(cmp_adr(0), d1);
        chk(d1, {16'h0, nc[0], ns[0]});
        rd(ctrl_adr(0), d1);
        chk(d1, 32'h10);
        rd(cmp_adr(2), d1);
        chk(d1, {16'h0, nc[2], ns[2]});
        wr(TIMER_MODE_CTRL_A_OFS, 32'h1);
        wr(TIMER_MODE_CTRL_B_OFS, 32'h3);
        for (int m = 0; m < METERS; m++) wait_flag(m);
        pulse_w(0, w1);
        chk(32'(w1), 32'(ns[0]) + 1);
        pulse_w(2, w1);
        chk(32'(w1), 32'(nc[0]) + 1);
        stagger(0, 1);
        stagger(16, 2);
        wr(ctrl_adr(0), 32'h14);
        wait_flag(0);
        pulse_w(0, w1);
        pulse_w(0, w2);
        chk(32'(w1 + w2), 2 * 32'(ns[0]) + 1);
        chk(32'((w1 > w2) ? w1 - w2 : w2 - w1), 32'h1);
        pulse_w(2, w1);
        chk(32'(w1), 32'(nc[0]) + 1);
        wr(ctrl_adr(0), 32'h18);
        wait_flag(0);
        pulse_w(2, w1);
        pulse_w(2, w2);
        chk(32'(w1 + w2), 2 * 32'(nc[0]) + 1);
        pulse_w(0, w1);
        chk(32'(w1), 32'(ns[0]) + 1);
        for (int q = 0; q < 4; q++) begin
            wr(ctrl_adr(0), 32'(16 | q));
            wait_flag(0);
            repeat (20) @(posedge ref_clk_i);
            clear_i <= 1'b1;
            @(posedge ref_clk_i);
            clear_i <= 1'b0;
            repeat (300) @(posedge ref_clk_i);
            chk(32'(seen_o[3:0]), 32'(qmask(q)));
            chk(32'(short_o), 32'h0);
        end
        d1 = 32'($urandom & 32'h00ff_ffff);
        wr(PORT_DATA_OFS, d1);
        wr(PORT_CTRL_OFS, 32'h1);
        repeat (3) @(negedge ref_clk_i);
        chk(32'(meter_pins_o), d1);
        @(posedge ref_clk_i);
        do_reset();
        rd(COUNTER_VALUE_OFS, d1);
        chk(d1, 32'h0);
        rd(PORT_CTRL_OFS, d1);
        chk(d1, 32'h0);
        wrap_up();
    end
endmodule
